// >>> src/mmd_top.sv
// Memory-map decoder with wait states, ordering protection and mode mapping
`timescale 1ns/100ps
`include "mmd_defines.svh"
module mmd_top import mmd_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input mmd_req_t [`MMD_LANES-1:0] i_req,
   input wire logic i_ext_ready,
   input wire logic i_mode_select_pin,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [`MMD_LANES-1:0] o_ack,
   output logic o_bus_err,
   output mmd_sel_t o_sel,
   output logic o_sel_vld,
   output logic o_zone_pair_low_select,
   output logic o_zone_pair_high_select,
   output logic o_zone2_select,
   output logic o_memory_mode_bit
);
   // =====================================================================
   // Declarations
   localparam logic [21:0] SEC_B [1:9] = '{`MMD_SEC1, `MMD_SEC2, `MMD_SEC3,
      `MMD_SEC4, `MMD_SEC5, `MMD_SEC6, `MMD_SEC7, `MMD_SEC8, `MMD_SEC9};
   mmd_state_t state_reg;
   mmd_sel_t sel_reg;
   mmd_sel_t sel_next;
   logic sel_vld_reg;
   logic [2:0] lane_reg;
   logic [2:0] pick;
   logic pick_vld;
   logic [4:0] ws_reg;
   logic [4:0] ws_next;
   logic pwd_reg;
   logic pwd_next;
   logic io_reg;
   logic align_next;
   logic done;
   logic ack_any;
   logic use_rdy;
   logic [4:0] cyc_reg;
   logic rdy_s1_reg;
   logic rdy_s2_reg;
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic strap_done_reg;
   logic mode_reg;
   logic prot_en_reg;
   logic last_prot_wr_reg;
   logic [19:0] zws_reg;
   logic [4:0] zrdy_reg;
   logic [3:0] fws_reg;
   logic [3:0] ows_reg;
   logic cs_low_reg;
   logic cs_high_reg;
   logic cs_z2_reg;
   logic [31:0] prdata_reg;
   logic slverr_reg;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic apb_wr;

   // =====================================================================
   // Functions
   // Flash sector number from a flash address
   function automatic logic [3:0] fn_sector(input logic [21:0] a);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 1; i <= 9; i++) begin
         if (a >= SEC_B[i]) begin
            n = 4'(i);
         end
      end
      return n;
   endfunction

   // Member of the ordering-protection group
   function automatic logic fn_in_group(input mmd_sel_t s);
      return (s.tgt == TGT_PF1) || (s.tgt == TGT_PF2) ||
         (s.tgt == TGT_ZONE && s.zone == `MMD_ZN1);
   endfunction

   // Address decode to exactly one target
   function automatic mmd_sel_t fn_decode(input logic [21:0] a, input logic prog,
      input logic io, input logic mp, input logic wr);
      mmd_sel_t s;
      s = '0;
      s.tgt = TGT_NONE;
      s.wr = wr;
      s.prog = prog;
      if (io) begin
         s.tgt = TGT_NONE;
      end else if (a <= `MMD_M1_HI) begin
         s.tgt = TGT_SINGLE_ACCESS_RAM_M;
      end else if (a <= `MMD_PF0_HI) begin
         s.tgt = prog ? TGT_NONE : TGT_PF0;
      end else if (a <= `MMD_Z0_HI) begin
         s.tgt = TGT_ZONE;
         s.zone = `MMD_ZN0;
      end else if (a <= `MMD_Z1_HI) begin
         s.tgt = TGT_ZONE;
         s.zone = `MMD_ZN1;
      end else if (a <= `MMD_PF1_HI) begin
         s.tgt = prog ? TGT_NONE : TGT_PF1;
      end else if (a <= `MMD_PF2_HI) begin
         s.tgt = prog ? TGT_NONE : TGT_PF2;
      end else if (a <= `MMD_L01_HI) begin
         s.tgt = TGT_SINGLE_ACCESS_RAM;
      end else if (a >= `MMD_Z2_LO && a <= `MMD_Z2_HI) begin
         s.tgt = TGT_ZONE;
         s.zone = `MMD_ZN2;
      end else if (a >= `MMD_Z6_LO && a <= `MMD_Z6_HI) begin
         s.tgt = TGT_ZONE;
         s.zone = `MMD_ZN6;
      end else if (a >= `MMD_OTP_LO && a <= `MMD_OTP_HI) begin
         s.tgt = TGT_OTP;
      end else if (a >= `MMD_FL_LO && a <= `MMD_FL_HI) begin
         s.tgt = TGT_FLASH;
         s.sector = fn_sector(a);
      end else if (a >= `MMD_H0_LO && a <= `MMD_H0_HI) begin
         s.tgt = TGT_SINGLE_ACCESS_RAM;
      end else if (a >= `MMD_Z7_LO) begin
         if (mp) begin
            s.tgt = TGT_ZONE;
            s.zone = `MMD_ZN7;
         end else if (a >= `MMD_BROM_LO) begin
            s.tgt = TGT_BROM;
         end
      end
      return s;
   endfunction

   // =====================================================================
   // Arbitration and decode of the winning lane
   // Lowest lane index wins: data write, program write, reads, fetch
   always_comb begin
      pick = 3'h0;
      pick_vld = 1'b0;
      for (int i = `MMD_LANES - 1; i >= 0; i--) begin
         if (i_req[i].vld) begin
            pick = 3'(i);
            pick_vld = 1'b1;
         end
      end
   end

   assign sel_next = fn_decode(i_req[pick].addr, pick[0] || pick[2], i_req[pick].io,
      mode_reg, pick == `MMD_LANE_DW || pick == `MMD_LANE_PW);
   assign pwd_next = i_req[pick].addr >= `MMD_PWD_LO && sel_next.tgt == TGT_FLASH;
   assign align_next = prot_en_reg && last_prot_wr_reg && !sel_next.wr &&
      fn_in_group(sel_next);

   // Wait-state count of the decoded target
   always_comb begin
      case (sel_next.tgt)
         TGT_PF1, TGT_PF2: ws_next = sel_next.wr ? `MMD_WS_ZERO : `MMD_WS_PF_RD;
         TGT_OTP: ws_next = (ows_reg == 4'h0) ? `MMD_WS_ONE : {1'b0, ows_reg};
         TGT_FLASH: ws_next = pwd_next ? `MMD_WS_PWD : {1'b0, fws_reg};
         TGT_BROM: ws_next = `MMD_WS_ONE;
         TGT_ZONE: begin
            ws_next = {1'b0, zws_reg[{sel_next.zone, 2'b00} +: 4]};
            if (ws_next == `MMD_WS_ZERO) begin
               ws_next = `MMD_WS_ONE;
            end
         end
         default: ws_next = `MMD_WS_ZERO;
      endcase
   end

   // =====================================================================
   // Access sequencer
   // One access at a time, held until its wait count expires and, for a ready-enabled zone, ready is high
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (pick_vld) begin
                  state_reg <= align_next ? ST_ALIGN : ST_START;
               end
            end
            ST_ALIGN: state_reg <= ST_START;
            ST_START: state_reg <= ST_WAIT;
            ST_WAIT: begin
               if (done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Capture of the granted access
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_reg <= '0;
         lane_reg <= 3'h0;
         ws_reg <= 5'h00;
         pwd_reg <= 1'b0;
         io_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && pick_vld) begin
         sel_reg <= sel_next;
         lane_reg <= pick;
         ws_reg <= ws_next;
         pwd_reg <= pwd_next;
         io_reg <= i_req[pick].io;
      end
   end

   // Target valid from grant to completion
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_vld_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && pick_vld) begin
         sel_vld_reg <= 1'b1;
      end else if (ack_any) begin
         sel_vld_reg <= 1'b0;
      end
   end

   // Chip selects; the zone pairs share one select each
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_low_reg <= 1'b0;
         cs_high_reg <= 1'b0;
         cs_z2_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && pick_vld && sel_next.tgt == TGT_ZONE) begin
         cs_low_reg <= sel_next.zone <= `MMD_ZN1;
         cs_high_reg <= sel_next.zone >= `MMD_ZN6;
         cs_z2_reg <= sel_next.zone == `MMD_ZN2;
      end else if (ack_any) begin
         cs_low_reg <= 1'b0;
         cs_high_reg <= 1'b0;
         cs_z2_reg <= 1'b0;
      end
   end

   // Track whether the last finished access was a protected write
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_prot_wr_reg <= 1'b0;
      end else if (ack_any) begin
         last_prot_wr_reg <= sel_reg.wr && fn_in_group(sel_reg);
      end
   end

   // Cycles spent in the wait phase, for status and checks
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cyc_reg <= 5'h00;
      end else if (state_reg == ST_START) begin
         cyc_reg <= 5'h00;
      end else if (state_reg == ST_WAIT && !done && cyc_reg != 5'h1F) begin
         cyc_reg <= cyc_reg + 5'h01;
      end
   end

   assign use_rdy = sel_reg.tgt == TGT_ZONE && zrdy_reg[sel_reg.zone];

   mmd_wait_ctr u_wait (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_load(state_reg == ST_START),
      .i_count(ws_reg),
      .i_use_rdy(use_rdy),
      .i_rdy(rdy_s2_reg),
      .o_done(done)
   );

   assign ack_any = state_reg == ST_WAIT && done;
   assign o_ack = ack_any ? 5'(5'h01 << lane_reg) : 5'h00;
   assign o_bus_err = ack_any && sel_reg.tgt == TGT_NONE;
   assign o_sel = sel_reg;
   assign o_sel_vld = sel_vld_reg;
   assign o_zone_pair_low_select = cs_low_reg;
   assign o_zone_pair_high_select = cs_high_reg;
   assign o_zone2_select = cs_z2_reg;
   assign o_memory_mode_bit = mode_reg;

   // =====================================================================
   // Ready pin synchroniser
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdy_s1_reg <= 1'b0;
         rdy_s2_reg <= 1'b0;
      end else begin
         rdy_s1_reg <= i_ext_ready;
         rdy_s2_reg <= rdy_s1_reg;
      end
   end

   // Mode pin synchroniser runs through reset so the strap sees the pin level
   always_ff @(posedge i_ref_clk) begin
      pin_s1_reg <= i_mode_select_pin;
      pin_s2_reg <= pin_s1_reg;
   end

   // Strap sampler, then software owns the mode bit
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_done_reg <= 1'b0;
         mode_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         mode_reg <= pin_s2_reg;
      end else if (apb_wr && i_paddr == `MMD_OFS_XCFG) begin
         mode_reg <= i_pwdata[0];
      end
   end

   // =====================================================================
   // APB register file
   assign apb_wr = i_psel && i_penable && i_pwrite;
   assign o_pready = 1'b1;
   assign o_prdata = prdata_reg;
   assign o_pslverr = i_penable && slverr_reg;

   // Timing and protection registers
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         zws_reg <= `MMD_ZWS_RST;
         zrdy_reg <= `MMD_ZRDY_RST;
         fws_reg <= `MMD_FWS_RST;
         ows_reg <= `MMD_FWS_RST;
         prot_en_reg <= 1'b1;
      end else if (apb_wr) begin
         case (i_paddr)
            `MMD_OFS_ZWS: zws_reg <= i_pwdata[19:0];
            `MMD_OFS_ZRDY: zrdy_reg <= i_pwdata[4:0];
            `MMD_OFS_FWS: begin
               fws_reg <= i_pwdata[3:0];
               ows_reg <= i_pwdata[7:4];
            end
            `MMD_OFS_PROT: prot_en_reg <= i_pwdata[0];
            default: prot_en_reg <= prot_en_reg;
         endcase
      end
   end

   // Read mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (i_paddr)
         `MMD_OFS_XCFG: rd_mux[0] = mode_reg;
         `MMD_OFS_ZWS: rd_mux[19:0] = zws_reg;
         `MMD_OFS_ZRDY: rd_mux[4:0] = zrdy_reg;
         `MMD_OFS_FWS: rd_mux[7:0] = {ows_reg, fws_reg};
         `MMD_OFS_PROT: rd_mux[0] = prot_en_reg;
         `MMD_OFS_STAT: rd_mux[14:0] = {cyc_reg, sel_reg.tgt, lane_reg,
            last_prot_wr_reg, mode_reg, state_reg != ST_IDLE};
         default: rd_hit = 1'b0;
      endcase
   end

   // Read data and error latched in the setup phase
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else if (i_psel && !i_penable) begin
         prdata_reg <= rd_mux;
         slverr_reg <= !rd_hit;
      end
   end

   // =====================================================================
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   property p_pf_data_only;
      sel_vld_reg && sel_reg.prog |-> !(sel_reg.tgt inside {TGT_PF0, TGT_PF1, TGT_PF2});
   endproperty
   a_pf_data_only: assert property (p_pf_data_only) else $error("frame via program");

   property p_align;
      state_reg == ST_IDLE && pick_vld && align_next |=> state_reg == ST_ALIGN ##1
         state_reg == ST_START;
   endproperty
   a_align: assert property (p_align) else $error("no align cycle");

   property p_prot_default;
      !strap_done_reg |-> prot_en_reg;
   endproperty
   a_prot_default: assert property (p_prot_default) else $error("protect off at reset");

   property p_cs_pair;
      o_zone_pair_low_select |-> sel_reg.tgt == TGT_ZONE && sel_reg.zone <= `MMD_ZN1 &&
         !o_zone_pair_high_select;
   endproperty
   a_cs_pair: assert property (p_cs_pair) else $error("low pair select wrong");

   property p_mode_map;
      sel_vld_reg |-> !(mode_reg && sel_reg.tgt == TGT_BROM) &&
         !(!mode_reg && sel_reg.tgt == TGT_ZONE && sel_reg.zone == `MMD_ZN7);
   endproperty
   a_mode_map: assert property (p_mode_map) else $error("boot or zone 7 wrong");

   property p_strap;
      $rose(strap_done_reg) |-> mode_reg == $past(pin_s2_reg);
   endproperty
   a_strap: assert property (p_strap) else $error("mode not strapped");

   property p_no_io;
      ack_any && io_reg |-> o_bus_err && !cs_low_reg && !cs_high_reg && !cs_z2_reg;
   endproperty
   a_no_io: assert property (p_no_io) else $error("io space decoded");

   property p_pf0_zero;
      ack_any && sel_reg.tgt == TGT_PF0 |-> cyc_reg == 5'h00;
   endproperty
   a_pf0_zero: assert property (p_pf0_zero) else $error("frame 0 waited");

   property p_pf_read_two;
      ack_any && sel_reg.tgt inside {TGT_PF1, TGT_PF2} && !sel_reg.wr |-> cyc_reg == 5'h02;
   endproperty
   a_pf_read_two: assert property (p_pf_read_two) else $error("frame read not two");

   property p_otp_min;
      ack_any && sel_reg.tgt == TGT_OTP |-> cyc_reg >= 5'h01;
   endproperty
   a_otp_min: assert property (p_otp_min) else $error("otp under one wait");

   property p_pwd;
      ack_any && pwd_reg |-> cyc_reg == 5'h10;
   endproperty
   a_pwd: assert property (p_pwd) else $error("password not sixteen");

   property p_ext_min;
      ack_any && sel_reg.tgt == TGT_ZONE |-> cyc_reg >= 5'h01;
   endproperty
   a_ext_min: assert property (p_ext_min) else $error("zone under one wait");

   property p_onehot;
      $onehot0(o_ack) and (ack_any |-> o_ack[lane_reg]);
   endproperty
   a_onehot: assert property (p_onehot) else $error("ack not single");

   property p_prio;
      state_reg == ST_IDLE && i_req[0].vld |=> lane_reg == `MMD_LANE_DW;
   endproperty
   a_prio: assert property (p_prio) else $error("data write not first");
endmodule // mmd_top

// >>> src/mmd_defines.svh
// Address map, wait-state figures and register offsets of the memory-map decoder
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
// =====================================================================
// Memory map (word addresses)
`define MMD_M1_HI 22'h0007FF
`define MMD_PF0_HI 22'h001FFF
`define MMD_Z0_HI 22'h003FFF
`define MMD_Z1_HI 22'h005FFF
`define MMD_PF1_HI 22'h006FFF
`define MMD_PF2_HI 22'h007FFF
`define MMD_L01_HI 22'h009FFF
`define MMD_Z2_LO 22'h080000
`define MMD_Z2_HI 22'h0FFFFF
`define MMD_Z6_LO 22'h100000
`define MMD_Z6_HI 22'h17FFFF
`define MMD_OTP_LO 22'h3D7800
`define MMD_OTP_HI 22'h3D7BFF
`define MMD_FL_LO 22'h3D8000
`define MMD_FL_HI 22'h3F7FFF
`define MMD_PWD_LO 22'h3F7FF8
`define MMD_H0_LO 22'h3F8000
`define MMD_H0_HI 22'h3F9FFF
`define MMD_Z7_LO 22'h3FC000
`define MMD_BROM_LO 22'h3FF000
// Flash sector starts after the first
`define MMD_SEC1 22'h3DA000
`define MMD_SEC2 22'h3DC000
`define MMD_SEC3 22'h3E0000
`define MMD_SEC4 22'h3E4000
`define MMD_SEC5 22'h3E8000
`define MMD_SEC6 22'h3EC000
`define MMD_SEC7 22'h3F0000
`define MMD_SEC8 22'h3F4000
`define MMD_SEC9 22'h3F6000
// =====================================================================
// Lanes, zones and wait states
`define MMD_LANES 5
`define MMD_LANE_DW 3'h0
`define MMD_LANE_PW 3'h1
`define MMD_ZN0 3'h0
`define MMD_ZN1 3'h1
`define MMD_ZN2 3'h2
`define MMD_ZN6 3'h3
`define MMD_ZN7 3'h4
`define MMD_WS_ZERO 5'h00
`define MMD_WS_ONE 5'h01
`define MMD_WS_PF_RD 5'h02
`define MMD_WS_PWD 5'h10
// =====================================================================
// Register offsets and reset values
`define MMD_OFS_XCFG 8'h00
`define MMD_OFS_ZWS 8'h04
`define MMD_OFS_ZRDY 8'h08
`define MMD_OFS_FWS 8'h0C
`define MMD_OFS_PROT 8'h10
`define MMD_OFS_STAT 8'h14
`define MMD_ZWS_RST 20'hFFFFF
`define MMD_ZRDY_RST 5'h1F
`define MMD_FWS_RST 4'hF
`endif

// >>> src/mmd_pkg.sv
// Types shared by the memory-map decoder files
package mmd_pkg;
   // Decoded target of one access
   typedef enum logic [3:0] {
      TGT_NONE, TGT_SINGLE_ACCESS_RAM_M, TGT_PF0, TGT_PF1, TGT_PF2,
      TGT_SINGLE_ACCESS_RAM, TGT_OTP, TGT_FLASH, TGT_BROM, TGT_ZONE
   } mmd_tgt_t;
   // One request lane from the core
   typedef struct packed {
      logic vld;
      logic io;
      logic [21:0] addr;
   } mmd_req_t;
   // Selected target of the access in flight
   typedef struct packed {
      mmd_tgt_t tgt;
      logic [2:0] zone;
      logic [3:0] sector;
      logic wr;
      logic prog;
   } mmd_sel_t;
   // Access sequencer states
   typedef enum {ST_IDLE, ST_ALIGN, ST_START, ST_WAIT} mmd_state_t;
endpackage

// >>> src/mmd_wait_ctr.sv
// Wait-state down counter with optional ready extension
`timescale 1ns/100ps
module mmd_wait_ctr (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [4:0] i_count,
   input wire logic i_use_rdy,
   input wire logic i_rdy,
   output logic o_done
);
   logic [4:0] cnt_reg;
   logic busy_reg;

   // Done once the count is spent and, if sampled, ready is high
   assign o_done = busy_reg && (cnt_reg == 5'h00) && (!i_use_rdy || i_rdy);

   // Count down after a load
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 5'h00;
         busy_reg <= 1'b0;
      end else if (i_load) begin
         cnt_reg <= i_count;
         busy_reg <= 1'b1;
      end else if (o_done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg && cnt_reg != 5'h00) begin
         cnt_reg <= cnt_reg - 5'h01;
      end
   end
endmodule // mmd_wait_ctr

// >>> tb/mmd_core_model.sv
// Processor core model that issues memory-bus requests on five lanes
`timescale 1ns/100ps
module mmd_core_model import mmd_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic [4:0] i_ack,
   input wire logic [16:0] i_mon,
   output mmd_req_t [4:0] o_req
);
   // =====================================================
   // Lane driver
   // All lanes idle at start
   initial o_req = '0;

   // Present one access, hold it until its ack, snapshot outputs at the ack
   task automatic access(input int ln, input logic [21:0] a, input logic io,
      output int n, output logic [16:0] m);
      n = 0;
      o_req[ln] <= '{1'h1, io, a};
      do begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end while (i_ack[ln] !== 1'h1 && n < 200);
      m = i_mon;
      @(posedge i_ref_clk);
      // Released lane shows the inverse, never the stale request
      o_req[ln] <= '{1'h0, ~io, ~a};
      @(posedge i_ref_clk);
   endtask
endmodule // mmd_core_model

// >>> tb/mmd_top_test.sv
// Self-checking bench of the memory-map decoder
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mmd_top_test import mmd_pkg::*; ;
   logic clk, rst_n, rdy, pin, psel, pen, pwr, e;
   logic [7:0] pa;
   logic [31:0] pwd, prd, r;
   logic prdy, perr, berr, svld, lo, hi, z2, mode;
   logic [4:0] ack;
   mmd_req_t [4:0] req;
   mmd_sel_t sel;
   logic [16:0] m;
   int n, checks, fail_count;

   mmd_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_ext_ready(rdy),
      .i_mode_select_pin(pin), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
      .o_ack(ack), .o_bus_err(berr), .o_sel(sel), .o_sel_vld(svld),
      .o_zone_pair_low_select(lo), .o_zone_pair_high_select(hi),
      .o_zone2_select(z2), .o_memory_mode_bit(mode));
   mmd_core_model core_u (.i_ref_clk(clk), .i_ack(ack),
      .i_mon({berr, lo, hi, z2, sel}), .o_req(req));

   // =====================================================
   // Clock and bus tasks
   // 40 MHz clock
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   task automatic reset(input logic p);
      pin <= p;
      rst_n <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      do begin
         @(posedge clk);
         k++;
      end while (prdy !== 1'h1 && k < 20);
      if (prdy !== 1'h1) fail_count++;
      r = prd;
      e = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask

   task automatic go(input int ln, input logic [21:0] a, input logic io = 1'h0);
      core_u.access(ln, a, io, n, m);
      if (n >= 200) fail_count++;
   endtask

   // =====================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] ofs [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
      logic [31:0] x [5] = '{32'hFFFFF, 32'h1F, 32'hFF, 32'h1, 32'h0};
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, ofs[i], 32'h0);
         `CHK(r, x[i])
         `CHK(e, 1'(i == 4))
      end
   endtask

   task automatic t_fixed();
      logic [21:0] a [6] = '{22'h100, 22'h800, 22'h8000, 22'h3F8000, 22'h6000, 22'h7000};
      int w [6] = '{0, 0, 0, 0, 2, 2};
      for (int i = 0; i < 6; i++) begin
         go(2, a[i]);
         `CHK(n, 2 + w[i])
         `CHK(m[16], 1'h0)
         `CHK(svld, 1'h0)
      end
      go(2, 22'h800);
      `CHK(m[12:9], TGT_PF0)
      go(3, 22'h6000);
      `CHK(m[16], 1'h1)
      go(1, 22'h7000);
      `CHK(m[16], 1'h1)
      go(2, 22'h2000, 1'h1);
      `CHK(m[16], 1'h1)
      go(3, 22'h3F6000);
      `CHK(m[5:2], 4'h9)
      go(2, 22'h3DC000);
      `CHK(m[5:2], 4'h2)
   endtask

   task automatic t_prot();
      go(0, 22'h6000);
      `CHK(n, 2)
      go(2, 22'h7000);
      `CHK(n, 5)
      apb(1'h1, 8'h10, 32'h0);
      go(0, 22'h7000);
      go(2, 22'h6000);
      `CHK(n, 4)
      apb(1'h1, 8'h10, 32'h1);
   endtask

   task automatic t_flash();
      go(3, 22'h3D8000);
      `CHK(n, 17)
      go(2, 22'h3F7FF8);
      `CHK(n, 18)
      apb(1'h1, 8'h0C, 32'h0);
      go(3, 22'h3D8000);
      `CHK(n, 2)
      go(4, 22'h3F7FF6);
      `CHK(n, 2)
      go(2, 22'h3D7800);
      `CHK(n, 3)
      go(2, 22'h3F7FFF);
      `CHK(n, 18)
   endtask

   task automatic t_zone();
      logic [21:0] a [4] = '{22'h2000, 22'h4000, 22'h80000, 22'h100000};
      logic [2:0] cs [4] = '{3'h4, 3'h4, 3'h1, 3'h2};
      int w [4] = '{1, 1, 2, 3};
      apb(1'h1, 8'h04, 32'h43201);
      apb(1'h1, 8'h08, 32'h4);
      for (int i = 0; i < 4; i++) begin
         go(2, a[i]);
         `CHK(n, 2 + w[i])
         `CHK(m[15:13], cs[i])
      end
      go(0, 22'h4000);
      go(2, 22'h6000);
      `CHK(n, 5)
      rdy <= 1'h0;
      go(2, 22'h2000);
      `CHK(n, 3)
      fork
         go(2, 22'h80000);
         begin
            repeat (20) @(posedge clk);
            rdy <= 1'h1;
         end
      join
      `CHK(n > 20, 1'h1)
   endtask

   task automatic t_mode();
      `CHK(mode, 1'h0)
      go(4, 22'h3FF000);
      `CHK(n, 3)
      `CHK(m[12:9], TGT_BROM)
      go(2, 22'h3FC000);
      `CHK(m[16], 1'h1)
      apb(1'h1, 8'h00, 32'h1);
      `CHK(mode, 1'h1)
      go(4, 22'h3FF000);
      `CHK(m[12:6], {TGT_ZONE, 3'h4})
      `CHK(m[14], 1'h1)
      `CHK(n, 6)
      go(2, 22'h3F8000);
      `CHK(n, 2)
      reset(1'h1);
      apb(1'h0, 8'h00, 32'h0);
      `CHK(r[0], 1'h1)
   endtask

   task automatic t_prio();
      int n2, n4;
      logic [16:0] x;
      fork
         core_u.access(4, 22'h8000, 1'h0, n4, x);
         core_u.access(2, 22'h8000, 1'h0, n2, x);
      join
      `CHK(n2, 2)
      `CHK(n4, 5)
   endtask

   task automatic give_verdict();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'h0;
      rdy = 1'h1;
      pin = 1'h0;
      psel = 1'h0;
      pen = 1'h0;
      pwr = 1'h0;
      pa = 8'h0;
      pwd = 32'h0;
      @(posedge clk);
      reset(1'h0);
      t_regs();
      t_fixed();
      t_prot();
      t_flash();
      t_zone();
      t_mode();
      t_prio();
      give_verdict();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
endmodule // mmd_top_test
